// ### mbs_sequencer.sv
// Mains bypass switch sequencer: drives input, output and mains contactors.
// Assumes all inputs synchronous to core_clk; interlock is external.
`timescale 1ns/1ps
`default_nettype none
module mbs_sequencer
   import mbs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic selectOwnDrive50hz,
   input wire logic selectOwnDrive60hz,
   input wire logic seqEnable,
   input wire logic runCommand,
   input wire logic mainCircuitReady,
   input wire logic [WAIT_W-1:0] restartWaitTime,
   input wire logic alarmSwitchoverSelect,
   input wire logic alarmActive,
   input wire logic deviceFailed,
   input wire logic resyncDone,
   output logic inputContactorDrive,
   output logic outputContactorDrive,
   output logic mainsContactorDrive,
   output logic gateEnable,
   output logic resyncRequest,
   output logic freq60hz
);
   mbs_state_type state_q;
   logic selRaw;
   logic sel_q;
   logic selRise;
   logic selFall;
   logic alarmDrop;
   logic toMains;
   logic toOwn;
   logic delayStart;
   logic delayDone;
   logic [CNT_W-1:0] delayLoad;
   logic [CNT_W-1:0] waitCyc;

   // Alarm with switchover set and device not failed is treated like the select dropping
   assign selRaw = (selectOwnDrive50hz | selectOwnDrive60hz) & seqEnable;
   assign alarmDrop = alarmActive & alarmSwitchoverSelect & !deviceFailed;
   assign selRise = selRaw & !sel_q & !alarmDrop;
   assign selFall = sel_q & (!selRaw | alarmDrop);
   assign toMains = selFall;
   assign toOwn = selRise;
   assign waitCyc = CNT_W'(restartWaitTime) * CNT_W'(WAIT_UNIT_CYC);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_q <= 1'b0;
      end else if (alarmDrop) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= selRaw;
      end
   end

   // Delay loads: fixed part plus restart wait for mains and resync delays
   always_comb begin
      delayStart = 1'b0;
      delayLoad = CNT_W'(FIXED_DELAY_CYC);
      if (toMains) begin
         delayStart = 1'b1;
         delayLoad = CNT_W'(FIXED_DELAY_CYC) + waitCyc;
      end else if (toOwn) begin
         delayStart = 1'b1;
         delayLoad = CNT_W'(FIXED_DELAY_CYC);
      end else if (state_q == MBS_OUT_WAIT && delayDone && mainCircuitReady) begin
         delayStart = 1'b1;
         delayLoad = CNT_W'(FIXED_DELAY_CYC) + waitCyc;
      end
   end

   mbs_delay u_delay (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .start(delayStart),
      .loadValue(delayLoad),
      .done(delayDone)
   );

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= MBS_IDLE;
      end else if (toMains) begin
         state_q <= MBS_MAINS_WAIT;
      end else if (toOwn) begin
         state_q <= MBS_OUT_WAIT;
      end else begin
         unique case (state_q)
            MBS_IDLE: begin
               state_q <= MBS_IDLE;
            end
            MBS_MAINS_WAIT: begin
               // Run absent at expiry: park in MBS_IDLE with mains open
               if (delayDone) begin
                  state_q <= runCommand ? MBS_MAINS_ON : MBS_IDLE;
               end
            end
            MBS_MAINS_ON: begin
               state_q <= MBS_MAINS_ON;
            end
            MBS_OUT_WAIT: begin
               // Input contactor may be unused; ready input alone gates progress
               if (delayDone && mainCircuitReady) begin
                  state_q <= MBS_RESYNC_WAIT;
               end
            end
            MBS_RESYNC_WAIT: begin
               if (delayDone) begin
                  state_q <= MBS_OWN_RUN;
               end
            end
            MBS_OWN_RUN: begin
               if (alarmActive && !alarmSwitchoverSelect) begin
                  state_q <= MBS_IDLE;
               end
            end
            default: begin
               state_q <= MBS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gateEnable <= RESET_DRIVE;
         resyncRequest <= RESET_DRIVE;
      end else if (toMains) begin
         gateEnable <= 1'b0;
         resyncRequest <= 1'b0;
      end else if (state_q == MBS_RESYNC_WAIT && delayDone) begin
         resyncRequest <= 1'b1;
      end else if (state_q == MBS_OWN_RUN && alarmActive && !alarmSwitchoverSelect) begin
         // Alarm stop wins over a resync answer in the same cycle
         gateEnable <= 1'b0;
         resyncRequest <= 1'b0;
      end else if (resyncRequest && resyncDone) begin
         resyncRequest <= 1'b0;
         gateEnable <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         inputContactorDrive <= RESET_DRIVE;
         outputContactorDrive <= RESET_DRIVE;
         mainsContactorDrive <= RESET_DRIVE;
      end else if (toMains) begin
         inputContactorDrive <= 1'b0;
         outputContactorDrive <= 1'b0;
      end else if (toOwn) begin
         inputContactorDrive <= 1'b1;
         mainsContactorDrive <= 1'b0;
      end else if (state_q == MBS_MAINS_WAIT && delayDone && runCommand) begin
         mainsContactorDrive <= 1'b1;
      end else if (state_q == MBS_OUT_WAIT && delayDone && mainCircuitReady) begin
         outputContactorDrive <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         freq60hz <= 1'b0;
      end else if (toOwn) begin
         freq60hz <= selectOwnDrive60hz;
      end
   end

   // Timed steps of both directions and the resync answer, named once
   sequence mainsExpiry_s;
      state_q == MBS_MAINS_WAIT && delayDone && !toOwn;
   endsequence

   sequence outExpiry_s;
      state_q == MBS_OUT_WAIT && delayDone && mainCircuitReady && !toMains && !toOwn;
   endsequence

   sequence resyncExpiry_s;
      state_q == MBS_RESYNC_WAIT && delayDone && !toMains;
   endsequence

   sequence resyncAnswer_s;
      resyncRequest && resyncDone && !toMains && !(alarmActive && !alarmSwitchoverSelect);
   endsequence

   fall_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      toMains |=> !gateEnable) else $error("Gating not cut on select fall");
   fall_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      toMains |=> !inputContactorDrive && !outputContactorDrive) else $error("Contactors not dropped");
   mains_close_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(mainsContactorDrive) |-> $past(state_q) == MBS_MAINS_WAIT && $past(runCommand))
      else $error("Mains closed without wait or run");
   mains_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (mainsExpiry_s ##0 runCommand) |=> mainsContactorDrive && state_q == MBS_MAINS_ON)
      else $error("Mains not closed at wait end");
   mains_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (mainsExpiry_s ##0 !runCommand) |=> !mainsContactorDrive && state_q == MBS_IDLE)
      else $error("Mains closed without run");
   rise_input_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      toOwn |=> inputContactorDrive) else $error("Input contactor not closed");
   rise_mains_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      toOwn |=> !mainsContactorDrive) else $error("Mains contactor not opened");
   out_close_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(outputContactorDrive) |-> $past(mainCircuitReady) && inputContactorDrive)
      else $error("Output closed before ready");
   out_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      outExpiry_s |=> outputContactorDrive && state_q == MBS_RESYNC_WAIT)
      else $error("Output not closed after ready");
   resync_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(gateEnable) |-> $past(resyncRequest) && outputContactorDrive)
      else $error("Gating resumed without resync");
   resync_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      resyncExpiry_s |=> resyncRequest && state_q == MBS_OWN_RUN)
      else $error("Resync not requested at wait end");
   resync_done_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      resyncAnswer_s |=> gateEnable && !resyncRequest)
      else $error("Gating not resumed after resync");
   alarm_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      state_q == MBS_OWN_RUN && alarmActive && !alarmSwitchoverSelect && !toMains |=> !gateEnable)
      else $error("Alarm did not stop drive");
   fail_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      deviceFailed && alarmActive && sel_q && selRaw |-> !toMains)
      else $error("Failed device switched to mains");
   enable_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !seqEnable |-> !toOwn) else $error("Sequence started while unassigned");
   delay_restart_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      delayStart |=> !delayDone) else $error("Delay did not restart");
   mains_excl_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !(mainsContactorDrive && outputContactorDrive)) else $error("Mains and output both driven");
endmodule
`default_nettype wire

// ### mbs_pkg.sv
// Package of constants for the mains bypass switch sequencer.
// Assumes a single 50 MHz core clock; all delays counted in that clock.
// How it works
// - Select falling cuts output stage gating at the next clock edge.
// - Select falling drops input and output contactor drives at once.
// - After 0.2 s plus restart wait, close mains contactor if run present.
// - Select rising closes input contactor drive at once.
// - Select rising opens mains contactor drive at once.
// - Output contactor closes 0.2 s after input contactor plus main-circuit ready.
// - After 0.2 s plus restart wait, resync to mains frequency, resume own drive.
// - Alarm setting 0 stops on alarm in MBS_OWN_RUN only; 1 switches automatically to mains.
// - Sequence works when input contactor is unused and power stays on.
// - Sequence keeps working after an internal alarm unless device failed.
// - Sequence active only when a select and both needed drives are assigned.
package mbs_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned FIXED_DELAY_MS = 200;
   localparam int unsigned FIXED_DELAY_CYC = CLK_HZ / 1000 * FIXED_DELAY_MS;
   localparam int unsigned WAIT_W = 16;
   localparam int unsigned WAIT_UNIT_MS = 100;
   localparam int unsigned WAIT_UNIT_CYC = CLK_HZ / 1000 * WAIT_UNIT_MS;
   localparam int unsigned CNT_W = 40;
   localparam logic RESET_DRIVE = 1'b0;

   typedef enum logic [2:0] {
      MBS_IDLE = 3'b000,
      MBS_MAINS_WAIT = 3'b001,
      MBS_MAINS_ON = 3'b010,
      MBS_OUT_WAIT = 3'b011,
      MBS_RESYNC_WAIT = 3'b100,
      MBS_OWN_RUN = 3'b101
   } mbs_state_type;
endpackage

// ### mbs_delay.sv
// Down-counting delay timer for the sequencer.
// Assumes start pulses come from the sequencer on core_clk.
`timescale 1ns/1ps
`default_nettype none
module mbs_delay
   import mbs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [CNT_W-1:0] loadValue,
   output logic done
);
   logic [CNT_W-1:0] count_q;
   logic running_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
         running_q <= 1'b0;
      end else if (start) begin
         // Restart on every start so a select change mid-wait begins afresh
         count_q <= loadValue;
         running_q <= 1'b1;
      end else if (count_q != '0) begin
         count_q <= count_q - 1'b1;
      end
   end

   // Expiry holds until next start, so a late ready is not missed
   // Start kept out of done: avoids a combinational loop via the caller
   assign done = running_q && (count_q == '0);
endmodule
`default_nettype wire

// ### mbs_partner.sv
// Partner model: main circuit readiness and motor resync responder.
// Assumes sequencer outputs change on core_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module mbs_partner (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic inputUsed,
   input wire logic inputContactorDrive,
   input wire logic resyncRequest,
   output logic mainCircuitReady,
   output logic resyncDone
);
   logic [3:0] readyCnt_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         readyCnt_q <= 4'h0;
      end else if (!inputContactorDrive) begin
         readyCnt_q <= 4'h0;
      end else if (readyCnt_q != 4'hf) begin
         readyCnt_q <= readyCnt_q + 4'h1;
      end
   end
   // Unused input contactor means power stays on, so always ready
   assign mainCircuitReady = !inputUsed || (readyCnt_q == 4'hf);
   // Answers one cycle late, never early
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         resyncDone <= 1'b0;
      end else begin
         resyncDone <= resyncRequest;
      end
   end
endmodule
`default_nettype wire

// ### mbs_sequencer_bench.sv
// Bench for the sequencer: directed and random select traffic.
// Assumes the 0.2 s delays never expire within this short run.
`timescale 1ns/1ps
`default_nettype none
module mbs_sequencer_bench
   import mbs_pkg::*;
();
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] drv = 6'h00;
   logic runCommand = 1'b0;
   logic inputUsed = 1'b1;
   logic [WAIT_W-1:0] restartWaitTime = '0;
   logic ready, resyncDone, inDrv, outDrv, mainsDrv, gateEnable, resyncRequest, freq60hz;
   int nErrors = 0;
   int checkCount = 0;
   int selPrev = 0;
   logic expF60 = 1'b0;
   logic selNow;
   bit [31:0] seed = 32'h9314_568c;
   logic [5:0] dir [9] = '{6'h05, 6'h04, 6'h06, 6'h02, 6'h06, 6'h1e, 6'h06, 6'h3e, 6'h0e};

   always #10 core_clk = ~core_clk;

   mbs_sequencer DUT (.core_clk(core_clk), .reset_n(reset_n), .selectOwnDrive50hz(drv[0]),
      .selectOwnDrive60hz(drv[1]), .seqEnable(drv[2]), .runCommand(runCommand),
      .mainCircuitReady(ready), .restartWaitTime(restartWaitTime), .alarmSwitchoverSelect(drv[4]),
      .alarmActive(drv[3]), .deviceFailed(drv[5]), .resyncDone(resyncDone),
      .inputContactorDrive(inDrv), .outputContactorDrive(outDrv), .mainsContactorDrive(mainsDrv),
      .gateEnable(gateEnable), .resyncRequest(resyncRequest), .freq60hz(freq60hz));

   mbs_partner partner (.core_clk(core_clk), .reset_n(reset_n), .inputUsed(inputUsed),
      .inputContactorDrive(inDrv), .resyncRequest(resyncRequest), .mainCircuitReady(ready),
      .resyncDone(resyncDone));

   function automatic bit [31:0] xs(bit [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic chk(string nm, logic seen, logic exp);
      checkCount++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s expected %b seen %b", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Applies {failed, alarmSel, alarm, enable, sel60, sel50} and compares with the model
   task automatic step(logic [5:0] v, int gap);
      @(posedge core_clk);
      drv <= v;
      repeat (gap) @(posedge core_clk);
      #1;
      selNow = (v[0] | v[1]) & v[2] & !(v[3] & v[4] & !v[5]);
      if (selNow && selPrev == 0) begin
         expF60 = v[1];
      end
      selPrev = selNow;
      chk("input drive", inDrv, selNow);
      chk("gate", gateEnable, 1'b0);
      chk("mains", mainsDrv, 1'b0);
      chk("output drive", outDrv, 1'b0);
      chk("freq select", freq60hz, expF60);
      chk("interlock", mainsDrv & outDrv, 1'b0);
      chk("resync request", resyncRequest, 1'b0);
   endtask

   initial begin
      repeat (100000) @(posedge core_clk);
      nErrors++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk("reset input", inDrv, 1'b0);
      chk("reset gate", gateEnable, 1'b0);
      foreach (dir[i]) begin
         step(dir[i], 3);
      end
      $display("test directed done");
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         restartWaitTime <= seed[31:16];
         runCommand <= seed[6];
         inputUsed <= (i < 30);
         // Never both selects at once
         step({seed[9] & seed[10], seed[8], seed[7] & seed[11], seed[2] | seed[3], seed[1] & !seed[0], seed[0]},
            2 + int'(seed[5:4]));
      end
      $display("test random done");
      wrap_up();
   end
endmodule
`default_nettype wire
